// ===== core/rpis_pkg.sv
// Package with offsets, field positions and carrier types of the port interrupt block
package rpis_pkg;
  localparam int NUM_PORTS = 4;
  localparam int SEL_W = 2;
  localparam int NUM_GPIO = 4;

  localparam logic [7:0] ADDR_PORT_SEL = 8'h4c;
  localparam logic [7:0] ADDR_EN_HIGH = 8'hd8;
  localparam logic [7:0] ADDR_EN_LOW = 8'hd9;
  localparam logic [7:0] ADDR_ST_HIGH = 8'hda;
  localparam logic [7:0] ADDR_ST_LOW = 8'hdb;
  localparam logic [7:0] ADDR_GPIO_ST = 8'hdc;
  localparam logic [7:0] ADDR_GPIO_EN = 8'hdd;

  // High enable and status field positions
  localparam int HI_ENC = 2;
  localparam int HI_SEQ = 1;
  localparam int HI_CRC = 0;
  // Low enable and status field positions
  localparam int LO_LEN = 6;
  localparam int LO_CNT = 5;
  localparam int LO_BUF = 4;
  localparam int LO_PAR = 2;
  localparam int LO_VALID = 1;
  localparam int LO_LOCK = 0;
  // GPIO status: flags in the upper nibble, live levels in the lower
  localparam int GPIO_FLAG_LSB = 4;

  localparam logic [2:0] HI_RESET = 3'h0;
  localparam logic [7:0] LO_RESET = 8'h00;
  localparam logic [7:0] LO_RW_MASK = 8'h77;
  localparam logic [7:0] GPIO_EN_RESET = 8'h00;
  localparam logic [SEL_W-1:0] SEL_RESET = 2'h0;

  typedef struct packed {
    logic enc_err;    // Encoding error pulse
    logic seq_err;    // Control channel sequence error pulse
    logic crc_err;    // Control channel CRC error pulse
    logic len_chg;    // Line length change pulse
    logic cnt_chg;    // Line count change pulse
    logic buf_ovf;    // Receive buffer overflow pulse
    logic par_err;    // Parity error pulse
    logic port_valid; // Port valid level
    logic lock;       // Lock level
    logic [NUM_GPIO-1:0] gpio; // Forward channel GPIO levels
  } rpis_evt_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpis_req_type;

  typedef struct packed {
    logic [2:0] en_hi;
    logic [7:0] en_lo;
    logic [2:0] st_hi;
    logic [7:0] st_lo;
    logic [7:0] gpio_en;
    logic [NUM_GPIO-1:0] gpio_flag;
    logic [NUM_GPIO-1:0] gpio_prev;
    logic lock_prev;
    logic valid_prev;
  } rpis_port_type;

  typedef struct packed {
    rpis_port_type [NUM_PORTS-1:0] p;
    logic [SEL_W-1:0] sel;
    logic [7:0] rdata;
    logic irq;
    logic primed;
  } rpis_state_type;
endpackage

// ===== core/rpis_port_irq.sv
// Per-port interrupt enable and status registers with port-select paging
// Notes on behaviour
// - Lock-change enable, low enable bit 0, lets a lock transition raise an interrupt.
// - High status bit 2 flags encoding error; cleared by port status two read.
// - High status bit 1 flags control sequence error; cleared by port status one read.
// - High status bit 0 flags control frame CRC error; cleared by status one read.
// - Low status bit 6 flags line length change; cleared by status two read.
// - Low status bit 5 flags line count change; cleared by status two read.
// - Low status bit 4 flags buffer overflow; cleared by status two read.
// - Low status bit 2 flags parity error; cleared by status one read.
// - Low status bit 1 flags port-valid change; cleared by status one read.
// - Low status bit 0 flags lock change; cleared by status one read.
// - GPIO status bits 7..4 latch GPIO 3..0 interrupts, cleared when read.
// - GPIO status bits 3..0 show live GPIO 3..0 levels, read-only.
// - GPIO enable bit 7 makes a falling GPIO 3 edge interrupt.
// - GPIO enable bit 6 makes a rising GPIO 3 edge interrupt.
// - Registers exist per port; port-select picks which copy accesses reach.
// - High enable bits 2..0 gate encoding, sequence and CRC interrupts.
// - GPIO enable bits 5..0 hold fall and rise enables for GPIO 2..0.
module rpis_port_irq (
  input wire logic clk_sys, // Core clock
  input wire logic rst, // Synchronous reset, active high
  input wire rpis_pkg::rpis_req_type req, // Register access from the serial slave
  input wire rpis_pkg::rpis_evt_type [rpis_pkg::NUM_PORTS-1:0] evt, // Per-port events
  input wire logic [rpis_pkg::NUM_PORTS-1:0] sts1_rd, // Port status one read pulses
  input wire logic [rpis_pkg::NUM_PORTS-1:0] sts2_rd, // Port status two read pulses
  output logic [7:0] reg_rdata, // Read data, valid the cycle after rd
  output logic irq // Interrupt request, active high
);
  rpis_pkg::rpis_state_type state_ff;
  rpis_pkg::rpis_state_type nxt_state;

  always_comb begin
    logic [rpis_pkg::NUM_GPIO-1:0] rise;
    logic [rpis_pkg::NUM_GPIO-1:0] fall;
    logic any;
    logic hit;
    rise = '0;
    fall = '0;
    any = 1'b0;
    hit = 1'b0;
    nxt_state = state_ff;
    // First cycle after reset only captures levels, so no false change is flagged
    nxt_state.primed = 1'b1;
    for (int i = 0; i < rpis_pkg::NUM_PORTS; i++) begin
      hit = (int'(state_ff.sel) == i);
      // Clears come first so that a same-cycle event wins
      if (sts1_rd[i]) begin
        nxt_state.p[i].st_hi[rpis_pkg::HI_SEQ] = 1'b0;
        nxt_state.p[i].st_hi[rpis_pkg::HI_CRC] = 1'b0;
        nxt_state.p[i].st_lo[rpis_pkg::LO_PAR] = 1'b0;
        nxt_state.p[i].st_lo[rpis_pkg::LO_VALID] = 1'b0;
        nxt_state.p[i].st_lo[rpis_pkg::LO_LOCK] = 1'b0;
      end
      if (sts2_rd[i]) begin
        nxt_state.p[i].st_hi[rpis_pkg::HI_ENC] = 1'b0;
        nxt_state.p[i].st_lo[rpis_pkg::LO_LEN] = 1'b0;
        nxt_state.p[i].st_lo[rpis_pkg::LO_CNT] = 1'b0;
        nxt_state.p[i].st_lo[rpis_pkg::LO_BUF] = 1'b0;
      end
      if (req.rd && hit && req.addr == rpis_pkg::ADDR_GPIO_ST) begin
        nxt_state.p[i].gpio_flag = '0;
      end
      if (evt[i].enc_err && state_ff.p[i].en_hi[rpis_pkg::HI_ENC]) begin
        nxt_state.p[i].st_hi[rpis_pkg::HI_ENC] = 1'b1;
      end
      if (evt[i].seq_err && state_ff.p[i].en_hi[rpis_pkg::HI_SEQ]) begin
        nxt_state.p[i].st_hi[rpis_pkg::HI_SEQ] = 1'b1;
      end
      if (evt[i].crc_err && state_ff.p[i].en_hi[rpis_pkg::HI_CRC]) begin
        nxt_state.p[i].st_hi[rpis_pkg::HI_CRC] = 1'b1;
      end
      if (evt[i].len_chg && state_ff.p[i].en_lo[rpis_pkg::LO_LEN]) begin
        nxt_state.p[i].st_lo[rpis_pkg::LO_LEN] = 1'b1;
      end
      if (evt[i].cnt_chg && state_ff.p[i].en_lo[rpis_pkg::LO_CNT]) begin
        nxt_state.p[i].st_lo[rpis_pkg::LO_CNT] = 1'b1;
      end
      if (evt[i].buf_ovf && state_ff.p[i].en_lo[rpis_pkg::LO_BUF]) begin
        nxt_state.p[i].st_lo[rpis_pkg::LO_BUF] = 1'b1;
      end
      if (evt[i].par_err && state_ff.p[i].en_lo[rpis_pkg::LO_PAR]) begin
        nxt_state.p[i].st_lo[rpis_pkg::LO_PAR] = 1'b1;
      end
      if (state_ff.primed && state_ff.p[i].en_lo[rpis_pkg::LO_VALID] &&
          evt[i].port_valid != state_ff.p[i].valid_prev) begin
        nxt_state.p[i].st_lo[rpis_pkg::LO_VALID] = 1'b1;
      end
      if (state_ff.primed && state_ff.p[i].en_lo[rpis_pkg::LO_LOCK] &&
          evt[i].lock != state_ff.p[i].lock_prev) begin
        nxt_state.p[i].st_lo[rpis_pkg::LO_LOCK] = 1'b1;
      end
      rise = evt[i].gpio & ~state_ff.p[i].gpio_prev;
      fall = ~evt[i].gpio & state_ff.p[i].gpio_prev;
      for (int g = 0; g < rpis_pkg::NUM_GPIO; g++) begin
        // Enable pairs: fall at bit 2g+1, rise at bit 2g
        if (state_ff.primed &&
            ((rise[g] && state_ff.p[i].gpio_en[2*g]) ||
             (fall[g] && state_ff.p[i].gpio_en[2*g+1]))) begin
          nxt_state.p[i].gpio_flag[g] = 1'b1;
        end
      end
      nxt_state.p[i].gpio_prev = evt[i].gpio;
      nxt_state.p[i].lock_prev = evt[i].lock;
      nxt_state.p[i].valid_prev = evt[i].port_valid;
      if (req.wr && hit) begin
        unique case (req.addr)
          rpis_pkg::ADDR_EN_HIGH: nxt_state.p[i].en_hi = req.wdata[2:0];
          rpis_pkg::ADDR_EN_LOW: nxt_state.p[i].en_lo = req.wdata & rpis_pkg::LO_RW_MASK;
          rpis_pkg::ADDR_GPIO_EN: nxt_state.p[i].gpio_en = req.wdata;
          default: ;
        endcase
      end
      any = any | (|(state_ff.p[i].st_hi & state_ff.p[i].en_hi)) |
            (|(state_ff.p[i].st_lo & state_ff.p[i].en_lo)) |
            (|state_ff.p[i].gpio_flag);
    end
    if (req.wr && req.addr == rpis_pkg::ADDR_PORT_SEL) begin
      nxt_state.sel = req.wdata[rpis_pkg::SEL_W-1:0];
    end
    if (req.rd) begin
      unique case (req.addr)
        rpis_pkg::ADDR_PORT_SEL: nxt_state.rdata = {6'h00, state_ff.sel};
        rpis_pkg::ADDR_EN_HIGH: nxt_state.rdata = {5'h00, state_ff.p[state_ff.sel].en_hi};
        rpis_pkg::ADDR_EN_LOW: nxt_state.rdata = state_ff.p[state_ff.sel].en_lo;
        rpis_pkg::ADDR_ST_HIGH: nxt_state.rdata = {5'h00, state_ff.p[state_ff.sel].st_hi};
        rpis_pkg::ADDR_ST_LOW: nxt_state.rdata = state_ff.p[state_ff.sel].st_lo;
        rpis_pkg::ADDR_GPIO_ST: nxt_state.rdata = {state_ff.p[state_ff.sel].gpio_flag,
                                                   state_ff.p[state_ff.sel].gpio_prev};
        // GPIO enable register is write-only, so it reads back zero
        default: nxt_state.rdata = 8'h00;
      endcase
    end
    // One cycle behind the flags; cheaper than a combinational path to the pin
    nxt_state.irq = any;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.sel <= rpis_pkg::SEL_RESET;
      for (int i = 0; i < rpis_pkg::NUM_PORTS; i++) begin
        state_ff.p[i].en_hi <= rpis_pkg::HI_RESET;
        state_ff.p[i].en_lo <= rpis_pkg::LO_RESET;
        state_ff.p[i].gpio_en <= rpis_pkg::GPIO_EN_RESET;
      end
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata = state_ff.rdata;
  assign irq = state_ff.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_lock_flag;
    state_ff.primed && state_ff.p[0].en_lo[rpis_pkg::LO_LOCK] &&
      evt[0].lock != state_ff.p[0].lock_prev |=> state_ff.p[0].st_lo[rpis_pkg::LO_LOCK];
  endproperty
  a_lock_flag: assert property (p_lock_flag) else $error("lock change not flagged");

  property p_enc_clear;
    sts2_rd[0] && !evt[0].enc_err |=> !state_ff.p[0].st_hi[rpis_pkg::HI_ENC];
  endproperty
  a_enc_clear: assert property (p_enc_clear) else $error("encode flag not cleared");

  property p_enc_set_wins;
    sts2_rd[0] && evt[0].enc_err && state_ff.p[0].en_hi[rpis_pkg::HI_ENC]
      |=> state_ff.p[0].st_hi[rpis_pkg::HI_ENC];
  endproperty
  a_enc_set_wins: assert property (p_enc_set_wins) else $error("encode event lost");

  property p_seq_clear;
    sts1_rd[0] && !evt[0].seq_err |=> !state_ff.p[0].st_hi[rpis_pkg::HI_SEQ];
  endproperty
  a_seq_clear: assert property (p_seq_clear) else $error("sequence flag not cleared");

  property p_crc_hold;
    state_ff.p[0].st_hi[rpis_pkg::HI_CRC] && !sts1_rd[0]
      |=> state_ff.p[0].st_hi[rpis_pkg::HI_CRC];
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("CRC flag dropped");

  property p_len_set;
    evt[0].len_chg && state_ff.p[0].en_lo[rpis_pkg::LO_LEN]
      |=> state_ff.p[0].st_lo[rpis_pkg::LO_LEN];
  endproperty
  a_len_set: assert property (p_len_set) else $error("line length not flagged");

  property p_cnt_masked;
    !state_ff.p[0].en_lo[rpis_pkg::LO_CNT] && !state_ff.p[0].st_lo[rpis_pkg::LO_CNT]
      |=> !state_ff.p[0].st_lo[rpis_pkg::LO_CNT];
  endproperty
  a_cnt_masked: assert property (p_cnt_masked) else $error("masked line count set");

  property p_buf_clear;
    sts2_rd[0] && !evt[0].buf_ovf |=> !state_ff.p[0].st_lo[rpis_pkg::LO_BUF];
  endproperty
  a_buf_clear: assert property (p_buf_clear) else $error("overflow flag not cleared");

  property p_par_clear;
    sts1_rd[0] && !evt[0].par_err |=> !state_ff.p[0].st_lo[rpis_pkg::LO_PAR];
  endproperty
  a_par_clear: assert property (p_par_clear) else $error("parity flag not cleared");

  property p_valid_flag;
    state_ff.primed && state_ff.p[0].en_lo[rpis_pkg::LO_VALID] &&
      $changed(evt[0].port_valid) && evt[0].port_valid != state_ff.p[0].valid_prev
      |=> state_ff.p[0].st_lo[rpis_pkg::LO_VALID];
  endproperty
  a_valid_flag: assert property (p_valid_flag) else $error("valid change not flagged");

  property p_gpio_rc;
    req.rd && req.addr == rpis_pkg::ADDR_GPIO_ST && state_ff.sel == 2'h0 &&
      evt[0].gpio == state_ff.p[0].gpio_prev |=> state_ff.p[0].gpio_flag == 4'h0;
  endproperty
  a_gpio_rc: assert property (p_gpio_rc) else $error("GPIO flags not cleared on read");

  property p_gpio_live;
    req.rd && req.addr == rpis_pkg::ADDR_GPIO_ST
      |=> reg_rdata[3:0] == $past(state_ff.p[state_ff.sel].gpio_prev);
  endproperty
  a_gpio_live: assert property (p_gpio_live) else $error("GPIO level readback wrong");

  property p_gpio3_fall;
    state_ff.primed && state_ff.p[0].gpio_en[7] && state_ff.p[0].gpio_prev[3] &&
      !evt[0].gpio[3] |=> state_ff.p[0].gpio_flag[3];
  endproperty
  a_gpio3_fall: assert property (p_gpio3_fall) else $error("GPIO3 fall missed");

  property p_gpio3_rise;
    state_ff.primed && state_ff.p[0].gpio_en[6] && !state_ff.p[0].gpio_prev[3] &&
      evt[0].gpio[3] |=> state_ff.p[0].gpio_flag[3];
  endproperty
  a_gpio3_rise: assert property (p_gpio3_rise) else $error("GPIO3 rise missed");

  property p_page_isolation;
    req.wr && req.addr == rpis_pkg::ADDR_EN_LOW && state_ff.sel != 2'h0
      |=> $stable(state_ff.p[0].en_lo);
  endproperty
  a_page_isolation: assert property (p_page_isolation) else $error("wrong port written");

  property p_irq_follow;
    (|(state_ff.p[0].st_lo & state_ff.p[0].en_lo)) |=> irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq not raised");

  property p_irq_quiet;
    !$past(state_ff.irq) && !irq && state_ff.p == '0 |=> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq without cause");

  property p_seq_set;
    evt[0].seq_err && state_ff.p[0].en_hi[rpis_pkg::HI_SEQ]
      |=> state_ff.p[0].st_hi[rpis_pkg::HI_SEQ];
  endproperty
  a_seq_set: assert property (p_seq_set) else $error("sequence error not flagged");

  property p_crc_set;
    evt[0].crc_err && state_ff.p[0].en_hi[rpis_pkg::HI_CRC]
      |=> state_ff.p[0].st_hi[rpis_pkg::HI_CRC];
  endproperty
  a_crc_set: assert property (p_crc_set) else $error("CRC error not flagged");

  property p_cnt_set;
    evt[0].cnt_chg && state_ff.p[0].en_lo[rpis_pkg::LO_CNT]
      |=> state_ff.p[0].st_lo[rpis_pkg::LO_CNT];
  endproperty
  a_cnt_set: assert property (p_cnt_set) else $error("line count not flagged");

  property p_buf_set;
    evt[0].buf_ovf && state_ff.p[0].en_lo[rpis_pkg::LO_BUF]
      |=> state_ff.p[0].st_lo[rpis_pkg::LO_BUF];
  endproperty
  a_buf_set: assert property (p_buf_set) else $error("overflow not flagged");

  property p_par_set;
    evt[0].par_err && state_ff.p[0].en_lo[rpis_pkg::LO_PAR]
      |=> state_ff.p[0].st_lo[rpis_pkg::LO_PAR];
  endproperty
  a_par_set: assert property (p_par_set) else $error("parity error not flagged");

  property p_len_clear;
    sts2_rd[0] && !evt[0].len_chg |=> !state_ff.p[0].st_lo[rpis_pkg::LO_LEN];
  endproperty
  a_len_clear: assert property (p_len_clear) else $error("line length flag not cleared");

  property p_cnt_clear;
    sts2_rd[0] && !evt[0].cnt_chg |=> !state_ff.p[0].st_lo[rpis_pkg::LO_CNT];
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("line count flag not cleared");

  property p_crc_clear;
    sts1_rd[0] && !evt[0].crc_err |=> !state_ff.p[0].st_hi[rpis_pkg::HI_CRC];
  endproperty
  a_crc_clear: assert property (p_crc_clear) else $error("CRC flag not cleared");

  property p_valid_clear;
    sts1_rd[0] && evt[0].port_valid == state_ff.p[0].valid_prev
      |=> !state_ff.p[0].st_lo[rpis_pkg::LO_VALID];
  endproperty
  a_valid_clear: assert property (p_valid_clear) else $error("valid flag not cleared");

  property p_lock_clear;
    sts1_rd[0] && evt[0].lock == state_ff.p[0].lock_prev
      |=> !state_ff.p[0].st_lo[rpis_pkg::LO_LOCK];
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock flag not cleared");

  property p_enc_masked;
    !state_ff.p[0].en_hi[rpis_pkg::HI_ENC] && !state_ff.p[0].st_hi[rpis_pkg::HI_ENC]
      |=> !state_ff.p[0].st_hi[rpis_pkg::HI_ENC];
  endproperty
  a_enc_masked: assert property (p_enc_masked) else $error("masked encode error set");

  property p_lock_masked;
    !state_ff.p[0].en_lo[rpis_pkg::LO_LOCK] && !state_ff.p[0].st_lo[rpis_pkg::LO_LOCK]
      |=> !state_ff.p[0].st_lo[rpis_pkg::LO_LOCK];
  endproperty
  a_lock_masked: assert property (p_lock_masked) else $error("masked lock change set");

  property p_gpio0_rise;
    state_ff.primed && state_ff.p[0].gpio_en[0] && !state_ff.p[0].gpio_prev[0] &&
      evt[0].gpio[0] |=> state_ff.p[0].gpio_flag[0];
  endproperty
  a_gpio0_rise: assert property (p_gpio0_rise) else $error("GPIO0 rise missed");

  property p_gpio0_fall;
    state_ff.primed && state_ff.p[0].gpio_en[1] && state_ff.p[0].gpio_prev[0] &&
      !evt[0].gpio[0] |=> state_ff.p[0].gpio_flag[0];
  endproperty
  a_gpio0_fall: assert property (p_gpio0_fall) else $error("GPIO0 fall missed");

  property p_gpio_irq;
    state_ff.p[0].gpio_flag != 4'h0 |=> irq;
  endproperty
  a_gpio_irq: assert property (p_gpio_irq) else $error("GPIO flag without irq");

  property p_clear_other;
    sts2_rd[0] && !sts1_rd[0] && state_ff.p[0].st_hi[rpis_pkg::HI_SEQ]
      |=> state_ff.p[0].st_hi[rpis_pkg::HI_SEQ];
  endproperty
  a_clear_other: assert property (p_clear_other) else $error("wrong read cleared flag");

  property p_sel_readback;
    req.rd && req.addr == rpis_pkg::ADDR_PORT_SEL
      |=> reg_rdata == {6'h00, $past(state_ff.sel)};
  endproperty
  a_sel_readback: assert property (p_sel_readback) else $error("port select readback");

  c_lock_irq: cover property (state_ff.p[0].st_lo[rpis_pkg::LO_LOCK] ##1 irq);
  c_gpio_read: cover property (state_ff.p[1].gpio_flag != 4'h0 ##1 req.rd);
  c_set_clear: cover property (sts2_rd[0] && evt[0].enc_err);
endmodule

// ===== verif/rpis_far_model.sv
// Behavioural far-side model that sends per-port link events
module rpis_far_model (
  input wire logic clk_sys, // Core clock
  output rpis_pkg::rpis_evt_type [rpis_pkg::NUM_PORTS-1:0] evt // Per-port events
);
  timeunit 1ns;
  timeprecision 100ps;

  initial evt = '0;

  // Pulses last one cycle; levels persist until the next send
  task automatic send(input int p, input rpis_pkg::rpis_evt_type e);
    @(posedge clk_sys);
    #1;
    evt[p] = e;
    @(posedge clk_sys);
    #1;
    evt[p][12:6] = '0;
  endtask
endmodule

// ===== verif/rpis_port_irq_tb.sv
// Self-checking bench of the per-port interrupt enable and status block
module rpis_port_irq_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  rpis_pkg::rpis_req_type req = '0;
  rpis_pkg::rpis_evt_type [rpis_pkg::NUM_PORTS-1:0] evt;
  logic [rpis_pkg::NUM_PORTS-1:0] sts1_rd = '0;
  logic [rpis_pkg::NUM_PORTS-1:0] sts2_rd = '0;
  logic [7:0] reg_rdata;
  logic irq;
  logic [7:0] exp_q [$];
  logic rd_d = 1'b0;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  // Status position of each event, high register in bits 10..8
  logic [10:0] emap [9] = '{11'h400, 11'h200, 11'h100, 11'h040, 11'h020, 11'h010,
                            11'h004, 11'h002, 11'h001};
  // Events whose flag belongs to port status two
  localparam logic [8:0] BY_TWO = 9'h039;
  logic [7:0] addrs [8] = '{rpis_pkg::ADDR_PORT_SEL, rpis_pkg::ADDR_EN_HIGH,
    rpis_pkg::ADDR_EN_LOW, rpis_pkg::ADDR_ST_HIGH, rpis_pkg::ADDR_ST_LOW,
    rpis_pkg::ADDR_GPIO_ST, rpis_pkg::ADDR_GPIO_EN, 8'he0};

  always #4 clk_sys = ~clk_sys;

  rpis_port_irq uut (.clk_sys(clk_sys), .rst(rst), .req(req), .evt(evt), .sts1_rd(sts1_rd),
    .sts2_rd(sts2_rd), .reg_rdata(reg_rdata), .irq(irq));
  rpis_far_model far (.clk_sys(clk_sys), .evt(evt));

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(posedge clk_sys);
    #1;
    req.wr = 1'b0;
  endtask

  // Notes the expected answer; the monitor compares it a cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    #1;
    req.rd = 1'b1;
    req.addr = a;
    exp_q.push_back(e);
    @(posedge clk_sys);
    #1;
    req.rd = 1'b0;
  endtask

  task automatic clr(input int p, input bit two);
    @(posedge clk_sys);
    #1;
    if (two) sts2_rd[p] = 1'b1;
    else sts1_rd[p] = 1'b1;
    @(posedge clk_sys);
    #1;
    sts1_rd = '0;
    sts2_rd = '0;
  endtask

  task automatic wait_irq(input logic e);
    @(posedge clk_sys);
    #1;
    check({7'h00, irq}, {7'h00, e});
  endtask

  always @(posedge clk_sys) begin
    rd_d <= req.rd;
    cyc <= cyc + 1;
    // Far above the expected run of about 1200 cycles
    if (cyc == 30000) begin
      fail_count++;
      print_verdict();
    end
  end

  always @(negedge clk_sys) begin
    if (rd_d === 1'b1) check(reg_rdata, exp_q.pop_front());
  end

  initial begin
    int p;
    int k;
    int g;
    int e;
    logic [7:0] v [4];
    logic [7:0] exp_gpio;
    rpis_pkg::rpis_evt_type ev;
    void'($urandom(32'hdc6e));
    repeat (4) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    $display("Test reset values done");

    for (p = 0; p < 4; p++) begin
      v[p] = 8'($urandom());
      wr(rpis_pkg::ADDR_PORT_SEL, 8'(p));
      wr(rpis_pkg::ADDR_EN_LOW, v[p]);
      wr(rpis_pkg::ADDR_EN_HIGH, ~v[p]);
      wr(rpis_pkg::ADDR_GPIO_EN, v[p]);
      wr(rpis_pkg::ADDR_ST_LOW, 8'hff);
    end
    for (p = 3; p >= 0; p--) begin
      wr(rpis_pkg::ADDR_PORT_SEL, 8'(p));
      rd(rpis_pkg::ADDR_PORT_SEL, 8'(p));
      rd(rpis_pkg::ADDR_EN_LOW, v[p] & rpis_pkg::LO_RW_MASK);
      rd(rpis_pkg::ADDR_EN_HIGH, ~v[p] & 8'h07);
      rd(rpis_pkg::ADDR_ST_LOW, 8'h00);
      rd(rpis_pkg::ADDR_GPIO_EN, 8'h00);
    end
    $display("Test paging and access done");

    for (p = 0; p < 4; p++) begin
      wr(rpis_pkg::ADDR_PORT_SEL, 8'(p));
      wr(rpis_pkg::ADDR_EN_HIGH, 8'h00);
      wr(rpis_pkg::ADDR_EN_LOW, 8'h00);
      ev = evt[p];
      ev[12:6] = '1;
      ev[5:4] = ~ev[5:4];
      far.send(p, ev);
      wait_irq(1'b0);
      rd(rpis_pkg::ADDR_ST_HIGH, 8'h00);
      rd(rpis_pkg::ADDR_ST_LOW, 8'h00);
      wr(rpis_pkg::ADDR_EN_HIGH, 8'h07);
      wr(rpis_pkg::ADDR_EN_LOW, 8'h77);
      for (k = 0; k < 9; k++) begin
        ev = evt[p];
        ev[12:6] = '0;
        ev[12-k] = ~ev[12-k];
        far.send(p, ev);
        check({7'h00, irq}, 8'h00);
        wait_irq(1'b1);
        rd(rpis_pkg::ADDR_ST_HIGH, {5'h00, emap[k][10:8]});
        clr(p, BY_TWO[k] == 1'b0);
        rd(rpis_pkg::ADDR_ST_LOW, emap[k][7:0]);
        clr(p, BY_TWO[k] == 1'b1);
        rd(rpis_pkg::ADDR_ST_HIGH, 8'h00);
        rd(rpis_pkg::ADDR_ST_LOW, 8'h00);
        wait_irq(1'b0);
      end
      // Event and clearing read in one cycle: the event must win
      ev = evt[p];
      ev[12:6] = '0;
      ev.enc_err = 1'b1;
      fork
        far.send(p, ev);
        clr(p, 1'b1);
      join
      rd(rpis_pkg::ADDR_ST_HIGH, 8'h04);
      clr(p, 1'b1);
      rd(rpis_pkg::ADDR_ST_HIGH, 8'h00);
      wait_irq(1'b0);
    end
    $display("Test status events done");

    k = $urandom_range(3);
    // Every port in turn, from a random first one
    for (int j = 0; j < 4; j++) begin
      p = (j + k) % 4;
      wr(rpis_pkg::ADDR_PORT_SEL, 8'(p));
      for (g = 0; g < 4; g++) begin
        // Third pass is a rise seen with only the fall enable set
        for (e = 0; e < 3; e++) begin
          wr(rpis_pkg::ADDR_GPIO_EN, 8'h01 << (2 * g + (e == 1 || e == 2)));
          ev = evt[p];
          ev[12:6] = '0;
          ev.gpio[g] = ~ev.gpio[g];
          far.send(p, ev);
          wait_irq(e < 2);
          exp_gpio = ((e < 2) ? (8'h10 << g) : 8'h00) | {4'h0, ev.gpio};
          rd(rpis_pkg::ADDR_GPIO_ST, exp_gpio);
          rd(rpis_pkg::ADDR_GPIO_ST, {4'h0, ev.gpio});
        end
      end
    end
    $display("Test forward gpio done");
    print_verdict();
  end
endmodule
